// ===== hdl/spm_pin_sel.sv
`timescale 1ns/1ps
// ======================================================================
// Registered pin selector: one socket pin, two functions
// ======================================================================
module spm_pin_sel
    import spm_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic sel_cb,
    input  wire logic a_out,
    input  wire logic a_oe,
    input  wire logic b_out,
    input  wire logic b_oe,
    output logic      pin_out,
    output logic      pin_oe
);
    logic nxt_out;
    logic nxt_oe;
    logic out_ff;
    logic oe_ff;

    // Mode picks which function owns the pin
    always_comb begin
        nxt_out = sel_cb ? b_out : a_out;
        nxt_oe  = sel_cb ? b_oe  : a_oe;
    end

    // Released on reset so nothing fights the card
    always_ff @(posedge clk) begin
        if (!nrst) begin
            out_ff <= 1'b1;
            oe_ff  <= 1'b0;
        end else begin
            out_ff <= nxt_out;
            oe_ff  <= nxt_oe;
        end
    end

    assign pin_out = out_ff;
    assign pin_oe  = oe_ff;
endmodule

// ===== hdl/spm_socket_mux.sv
`timescale 1ns/1ps
module spm_socket_mux
    import spm_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   nrst,
    // Socket configuration
    input  wire logic [1:0]             socket_mode,
    input  wire logic                   card_identified,
    input  wire logic [1:0]             vcc_req,
    input  wire logic [1:0]             vpp_req,
    // 16-bit cycle request
    input  wire logic [2:0]             cycle_kind,
    input  wire logic                   attr_space,
    input  wire logic                   dma_capable,
    input  wire logic                   dma_ack_req,
    input  wire logic [25:16]           addr_16,
    input  wire logic                   addr_oe,
    // CardBus side from the bus engine
    input  wire logic [19:16]           cad_out,
    input  wire logic [19:16]           cad_oe,
    output logic      [19:16]           cad_in,
    input  wire logic                   cbe3_out_n,
    input  wire logic                   cbe3_oe,
    output logic                        cbe3_in_n,
    input  wire logic [SPM_CTL_W-1:0]   cb_ctl_out_n,
    input  wire logic [SPM_CTL_W-1:0]   cb_ctl_oe,
    output logic      [SPM_CTL_W-1:0]   cb_ctl_in_n,
    input  wire logic                   card_clk_en,
    input  wire logic                   card_clk_src,
    // Socket status lines, passed through as plain levels
    input  wire logic [1:0]             card_detect_pair_n,
    input  wire logic                   card_audio_line,
    input  wire logic                   card_status_change,
    input  wire logic [1:0]             card_voltage_sense,
    output logic [1:0]                  card_detect_n_q,
    output logic                        card_audio_q,
    output logic                        card_status_q,
    output logic [1:0]                  card_vsense_q,
    // Power switch pins
    output logic                        supply_sel_low_n,
    output logic                        supply_sel_high_n,
    output logic                        prog_volt_sel_a,
    output logic                        prog_volt_sel_b,
    // Register select / byte enable 3 pin
    input  wire logic                   reg_sel_in,
    output logic                        reg_sel_out,
    output logic                        reg_sel_oe,
    // High socket address pins 16..25
    input  wire logic [25:16]           sock_hi_in,
    output logic      [25:16]           sock_hi_out,
    output logic      [25:16]           sock_hi_oe,
    output logic                        dma_acknowledge,
    output logic                        cardbus_active
);

    // ==================================================================
    // Socket mode latch
    // ==================================================================
    logic [1:0] mode_ff;
    logic [1:0] nxt_mode;
    logic       is_cb;
    logic       is_ata;

    // Mode only moves once the card type is known, so pins never
    // flip on a half-identified card
    always_comb begin
        nxt_mode = mode_ff;
        if (card_identified) begin
            nxt_mode = socket_mode;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_ff <= SPM_MODE_16;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    assign is_cb  = (mode_ff == SPM_MODE_CB);
    assign is_ata = (mode_ff == SPM_MODE_ATA);
    assign cardbus_active = is_cb;

    // ==================================================================
    // Power switch code
    // ==================================================================
    logic [1:0] vcc_ff;
    logic [1:0] vpp_ff;
    logic [1:0] nxt_vcc;
    logic [1:0] nxt_vpp;

    function automatic logic [1:0] spm_vcc_code(input logic [1:0] req);
        case (req)
            SPM_REQ_VCC_5V:  spm_vcc_code = SPM_VCC_5V;
            SPM_REQ_VCC_3V3: spm_vcc_code = SPM_VCC_3V3;
            default:         spm_vcc_code = SPM_VCC_OFF;
        endcase
    endfunction

    function automatic logic [1:0] spm_vpp_code(input logic [1:0] req);
        case (req)
            SPM_REQ_VPP_VCC: spm_vpp_code = SPM_VPP_VCC;
            SPM_REQ_VPP_12V: spm_vpp_code = SPM_VPP_12V;
            default:         spm_vpp_code = SPM_VPP_SW;
        endcase
    endfunction

    // Supply off forces the prog code to switch-dependent as well
    always_comb begin
        nxt_vcc = spm_vcc_code(vcc_req);
        nxt_vpp = (nxt_vcc == SPM_VCC_OFF) ? SPM_VPP_SW
                                           : spm_vpp_code(vpp_req);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            vcc_ff <= SPM_VCC_OFF;
            vpp_ff <= SPM_VPP_SW;
        end else begin
            vcc_ff <= nxt_vcc;
            vpp_ff <= nxt_vpp;
        end
    end

    assign supply_sel_low_n  = vcc_ff[1];
    assign supply_sel_high_n = vcc_ff[0];
    assign prog_volt_sel_a   = vpp_ff[1];
    assign prog_volt_sel_b   = vpp_ff[0];

    // ==================================================================
    // Register select for 16-bit cycles
    // ==================================================================
    logic reg16_out;
    logic reg16_oe;
    logic dma_acknowledge_ff;
    logic nxt_dma_acknowledge;

    // DMA wins over ATA; ATA wins over memory and I/O decoding
    always_comb begin
        reg16_out = 1'b1;
        reg16_oe  = 1'b1;
        nxt_dma_acknowledge  = 1'b0;
        if (cycle_kind == SPM_CYC_DMA && dma_capable) begin
            reg16_out = ~dma_ack_req;
            nxt_dma_acknowledge  = dma_ack_req;
        end else if (is_ata) begin
            reg16_out = 1'b1;
        end else if (cycle_kind == SPM_CYC_MEM) begin
            reg16_out = ~attr_space;
        end else if (cycle_kind == SPM_CYC_IO) begin
            reg16_out = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            dma_acknowledge_ff <= 1'b0;
        end else begin
            dma_acknowledge_ff <= is_cb ? 1'b0 : nxt_dma_acknowledge;
        end
    end

    assign dma_acknowledge = dma_acknowledge_ff;

    spm_pin_sel u_reg_pin (
        .clk     (clk),
        .nrst    (nrst),
        .sel_cb  (is_cb),
        .a_out   (reg16_out),
        .a_oe    (reg16_oe),
        .b_out   (cbe3_out_n),
        .b_oe    (cbe3_oe),
        .pin_out (reg_sel_out),
        .pin_oe  (reg_sel_oe)
    );

    // ==================================================================
    // High address pins: per-pin CardBus function
    // ==================================================================
    logic [SPM_PIN_W-1:0] cb_out;
    logic [SPM_PIN_W-1:0] cb_oe;

    // Card clock is gated by the engine; held high when stopped
    always_comb begin
        cb_out = {SPM_PIN_W{1'b1}};
        cb_oe  = {SPM_PIN_W{1'b0}};
        cb_out[SPM_P_A16] = card_clk_en ? card_clk_src : 1'b1;
        cb_oe[SPM_P_A16]  = 1'b1;
        cb_out[SPM_P_A17] = cad_out[SPM_CAD_A17];
        cb_oe[SPM_P_A17]  = cad_oe[SPM_CAD_A17];
        cb_out[SPM_P_A18] = 1'b1;
        cb_oe[SPM_P_A18]  = 1'b0;
        cb_out[SPM_P_A23:SPM_P_A19] = cb_ctl_out_n;
        cb_oe[SPM_P_A23:SPM_P_A19]  = cb_ctl_oe;
        cb_out[SPM_P_A24] = cad_out[SPM_CAD_A24];
        cb_oe[SPM_P_A24]  = cad_oe[SPM_CAD_A24];
    end

    genvar gi;
    generate
        for (gi = 0; gi < SPM_PIN_W; gi++) begin : g_pin
            spm_pin_sel u_pin (
                .clk     (clk),
                .nrst    (nrst),
                .sel_cb  (is_cb),
                .a_out   (addr_16[SPM_ADDR_LO + gi]),
                .a_oe    (addr_oe),
                .b_out   (cb_out[gi]),
                .b_oe    (cb_oe[gi]),
                .pin_out (sock_hi_out[SPM_ADDR_LO + gi]),
                .pin_oe  (sock_hi_oe[SPM_ADDR_LO + gi])
            );
        end
    endgenerate

    // Address 25 carries address/data bit 19 in CardBus mode
    spm_pin_sel u_a25 (
        .clk     (clk),
        .nrst    (nrst),
        .sel_cb  (is_cb),
        .a_out   (addr_16[25]),
        .a_oe    (addr_oe),
        .b_out   (cad_out[SPM_CAD_A25]),
        .b_oe    (cad_oe[SPM_CAD_A25]),
        .pin_out (sock_hi_out[25]),
        .pin_oe  (sock_hi_oe[25])
    );

    // ==================================================================
    // Inputs back from the socket, registered
    // ==================================================================
    logic [19:16]         cad_in_ff;
    logic [SPM_CTL_W-1:0] ctl_in_ff;
    logic                 cbe3_in_ff;
    logic [5:0]           stat_ff;
    logic [19:16]         nxt_cad_in;

    always_comb begin
        nxt_cad_in = 4'hf;
        nxt_cad_in[SPM_CAD_A17] = sock_hi_in[17];
        nxt_cad_in[SPM_CAD_A24] = sock_hi_in[24];
        nxt_cad_in[SPM_CAD_A25] = sock_hi_in[25];
    end

    // Status lines keep socket behaviour in every mode
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cad_in_ff  <= 4'hf;
            ctl_in_ff  <= {SPM_CTL_W{1'b1}};
            cbe3_in_ff <= 1'b1;
            stat_ff    <= 6'h3c;
        end else begin
            cad_in_ff  <= nxt_cad_in;
            ctl_in_ff  <= sock_hi_in[23:19];
            cbe3_in_ff <= reg_sel_in;
            stat_ff    <= {card_detect_pair_n, card_voltage_sense,
                           card_audio_line, card_status_change};
        end
    end

    assign cad_in          = cad_in_ff;
    assign cb_ctl_in_n     = ctl_in_ff;
    assign cbe3_in_n       = cbe3_in_ff;
    assign card_detect_n_q = stat_ff[5:4];
    assign card_vsense_q   = stat_ff[3:2];
    assign card_audio_q    = stat_ff[1];
    assign card_status_q   = stat_ff[0];

endmodule

// ===== shared/spm_pkg.sv
package spm_pkg;

    // ==================================================================
    // Socket mode and cycle kinds
    // ==================================================================
    typedef enum logic [1:0] {
        SPM_MODE_16  = 2'h0,
        SPM_MODE_ATA = 2'h1,
        SPM_MODE_CB  = 2'h2
    } spm_mode_e;

    typedef enum logic [2:0] {
        SPM_CYC_IDLE = 3'h0,
        SPM_CYC_MEM  = 3'h1,
        SPM_CYC_IO   = 3'h2,
        SPM_CYC_DMA  = 3'h3
    } spm_cycle_e;

    // ==================================================================
    // Power switch codes {sel_low_n, sel_high_n} and {prog_a, prog_b}
    // ==================================================================
    localparam logic [1:0] SPM_VCC_OFF  = 2'h3;
    localparam logic [1:0] SPM_VCC_5V   = 2'h1;
    localparam logic [1:0] SPM_VCC_3V3  = 2'h2;
    localparam logic [1:0] SPM_VPP_SW   = 2'h0;
    localparam logic [1:0] SPM_VPP_VCC  = 2'h1;
    localparam logic [1:0] SPM_VPP_12V  = 2'h2;

    // Request encodings on the control ports
    localparam logic [1:0] SPM_REQ_VCC_OFF = 2'h0;
    localparam logic [1:0] SPM_REQ_VCC_5V  = 2'h1;
    localparam logic [1:0] SPM_REQ_VCC_3V3 = 2'h2;
    localparam logic [1:0] SPM_REQ_VPP_SW  = 2'h0;
    localparam logic [1:0] SPM_REQ_VPP_VCC = 2'h1;
    localparam logic [1:0] SPM_REQ_VPP_12V = 2'h2;

    // ==================================================================
    // Shared high socket pins: index into the 9-pin group
    // ==================================================================
    localparam int SPM_PIN_W   = 9;
    localparam int SPM_P_A16   = 0;
    localparam int SPM_P_A17   = 1;
    localparam int SPM_P_A18   = 2;
    localparam int SPM_P_A19   = 3;
    localparam int SPM_P_A20   = 4;
    localparam int SPM_P_A21   = 5;
    localparam int SPM_P_A22   = 6;
    localparam int SPM_P_A23   = 7;
    localparam int SPM_P_A24   = 8;
    localparam int SPM_ADDR_LO = 16;
    localparam int SPM_CAD_A17 = 16;
    localparam int SPM_CAD_A24 = 17;
    localparam int SPM_CAD_A25 = 19;
    localparam int SPM_CTL_W   = 5;

endpackage

// ===== test/spm_card_model.sv
`timescale 1ns/1ps
// ==============================
// Card and power switch model
// ==============================
module spm_card_model (
    input  logic         clk,
    input  logic         cb,
    input  logic [25:16] hi_out,
    input  logic [25:16] hi_oe,
    input  logic [25:16] card_oe,
    input  logic [25:16] card_val,
    input  logic         rs_out,
    input  logic         rs_oe,
    input  logic [1:0]   sup_n,
    output logic [25:16] hi_in,
    output logic         rs_in,
    output logic [15:0]  vcc_mv
);
    logic [25:16] last_ff = '0;
    logic         rs_last_ff = 1'b0;
    // Released lines toggle, except the pull-ups on 19 to 22, so a stale value never looks valid
    always_comb begin
        for (int i = 16; i < 26; i++) begin
            if (hi_oe[i]) hi_in[i] = hi_out[i];
            else if (cb && card_oe[i]) hi_in[i] = card_val[i];
            else if (i > 18 && i < 23) hi_in[i] = 1'b1; // Pull-ups
            else hi_in[i] = ~last_ff[i];
        end
        rs_in = rs_oe ? rs_out : ~rs_last_ff;
    end
    // Last wire levels
    always_ff @(posedge clk) begin
        last_ff <= hi_in;
        rs_last_ff <= rs_in;
    end
    // Supply switch decode, millivolts
    always_comb begin
        case (sup_n)
            2'h1: vcc_mv = 16'h1388;
            2'h2: vcc_mv = 16'h0ce4;
            default: vcc_mv = 16'h0000;
        endcase
    end
endmodule

// ===== test/spm_socket_mux_asserts.sv
`timescale 1ns/1ps
// ==============================
// Port checks for the pin mux
// ==============================
module spm_socket_mux_asserts
    import spm_pkg::*;
(
    input logic                 clk,
    input logic                 nrst,
    input logic [1:0]           socket_mode,
    input logic                 card_identified,
    input logic [1:0]           vcc_req,
    input logic [1:0]           vpp_req,
    input logic [2:0]           cycle_kind,
    input logic                 attr_space,
    input logic                 dma_capable,
    input logic                 dma_ack_req,
    input logic [25:16]         addr_16,
    input logic                 addr_oe,
    input logic [19:16]         cad_out,
    input logic                 cbe3_out_n,
    input logic [SPM_CTL_W-1:0] cb_ctl_out_n,
    input logic                 card_clk_en,
    input logic                 card_clk_src,
    input logic                 supply_sel_low_n,
    input logic                 supply_sel_high_n,
    input logic                 prog_volt_sel_a,
    input logic                 prog_volt_sel_b,
    input logic                 reg_sel_out,
    input logic                 reg_sel_oe,
    input logic                 dma_acknowledge,
    input logic [25:16]         sock_hi_out,
    input logic [25:16]         sock_hi_oe,
    input logic                 cardbus_active
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!nrst);
    // Mode requests taken while the card is identified
    sequence s_m16; card_identified && socket_mode == SPM_MODE_16; endsequence
    sequence s_ata; card_identified && socket_mode == SPM_MODE_ATA; endsequence
    sequence s_cb; card_identified && socket_mode == SPM_MODE_CB; endsequence
    // Power codes one cycle after the request
    a_supply_code: assert property (
        vcc_req inside {2'h1, 2'h2} |=> {supply_sel_low_n, supply_sel_high_n}
        == ($past(vcc_req) == 2'h1 ? 2'h1 : 2'h2)) else $error("supply code");
    a_prog_code: assert property (
        vcc_req inside {2'h1, 2'h2} && vpp_req inside {2'h1, 2'h2} |=>
        {prog_volt_sel_a, prog_volt_sel_b} == $past(vpp_req)) else $error("prog");
    // Register select: latched mode, then the cycle kind
    a_reg_mem: assert property (
        s_m16 ##1 cycle_kind == SPM_CYC_MEM |=>
        reg_sel_out == !$past(attr_space)) else $error("reg sel memory");
    a_reg_io: assert property (
        s_m16 ##1 cycle_kind == SPM_CYC_IO |=> !reg_sel_out && reg_sel_oe)
        else $error("reg sel io");
    a_reg_ata: assert property (
        s_ata ##1 cycle_kind != SPM_CYC_DMA |=> reg_sel_out)
        else $error("reg sel ata");
    a_dma_ack: assert property (
        s_m16 ##1 (cycle_kind == SPM_CYC_DMA && dma_capable) |=>
        reg_sel_out == !$past(dma_ack_req)) else $error("dma ack");
    a_dma_acknowledge_out: assert property (
        s_m16 ##1 (cycle_kind == SPM_CYC_DMA && dma_capable) |=>
        dma_acknowledge == $past(dma_ack_req)) else $error("dma ack out");
    a_addr_16: assert property (
        s_m16 ##1 1'b1 |=> sock_hi_out == $past(addr_16) &&
        sock_hi_oe == {10{$past(addr_oe)}}) else $error("address pins");
    a_cb_map: assert property (
        s_cb ##1 1'b1 |=> sock_hi_out[23:19] == $past(cb_ctl_out_n) &&
        {sock_hi_out[25:24], sock_hi_out[17]} == $past({cad_out[19],
        cad_out[17], cad_out[16]}) && reg_sel_out == $past(cbe3_out_n))
        else $error("cardbus pin map");
    a_card_clk: assert property (
        s_cb ##1 card_clk_en |=> sock_hi_oe[16] &&
        sock_hi_out[16] == $past(card_clk_src)) else $error("card clock");
    a_rfu_free: assert property (
        s_cb ##1 1'b1 |=> !sock_hi_oe[18]) else $error("reserved pin");
    a_mode_latch: assert property (
        s_cb |=> cardbus_active) else $error("mode latch");
endmodule
bind spm_socket_mux spm_socket_mux_asserts i_chk (.*);

// ===== test/spm_socket_mux_bench.sv
`timescale 1ns/1ps
// ==============================
// Bench for the socket pin mux
// ==============================
module spm_socket_mux_bench
    import spm_pkg::*;
();
    typedef struct packed {
        logic [15:0]  mv;
        logic [1:0]   pp;
        logic         rs;
        logic         ro;
        logic         dk;
        logic [5:0]   st;
        logic [25:16] hi;
        logic [25:16] hoe;
        logic         cb;
    } spm_exp_s;
    logic         clk = 1'b0, nrst = 1'b0;
    logic [1:0]   socket_mode, vcc_req, vpp_req, card_detect_pair_n;
    logic [1:0]   card_voltage_sense, card_detect_n_q, card_vsense_q;
    logic [2:0]   cycle_kind;
    logic         card_identified, attr_space, dma_capable, dma_ack_req;
    logic         addr_oe, cbe3_out_n, cbe3_oe, cbe3_in_n, card_clk_en;
    logic         card_clk_src, card_audio_line, card_status_change;
    logic         card_audio_q, card_status_q, supply_sel_low_n;
    logic         supply_sel_high_n, prog_volt_sel_a, prog_volt_sel_b;
    logic         reg_sel_in, reg_sel_out, reg_sel_oe, dma_acknowledge;
    logic         cardbus_active;
    logic [25:16] addr_16, sock_hi_in, sock_hi_out, sock_hi_oe;
    logic [25:16] card_oe, card_val;
    logic [19:16] cad_out, cad_oe, cad_in;
    logic [4:0]   cb_ctl_out_n, cb_ctl_oe, cb_ctl_in_n, neg_ctl;
    logic [15:0]  vcc_mv;
    logic [3:0]   neg_cad;
    logic         neg_rs;
    logic [5:0]   stat_q;
    logic [1:0]   m = 2'h0;
    int           error_cnt = 0, cmp_count = 0, cyc = 0;
    spm_exp_s     q[$];
    spm_socket_mux i_dut (.*);
    spm_card_model i_card (
        .clk      (clk),
        .cb       (cardbus_active),
        .hi_out   (sock_hi_out),
        .hi_oe    (sock_hi_oe),
        .card_oe  (card_oe),
        .card_val (card_val),
        .rs_out   (reg_sel_out),
        .rs_oe    (reg_sel_oe),
        .sup_n    ({supply_sel_low_n, supply_sel_high_n}),
        .hi_in    (sock_hi_in),
        .rs_in    (reg_sel_in),
        .vcc_mv   (vcc_mv)
    );
    always #2.5 clk = ~clk;
    // Status copies gathered for one compare
    assign stat_q = {card_detect_n_q, card_vsense_q, card_audio_q,
                     card_status_q};
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Random inputs; DMA also toward cards that cannot take it
    task automatic stim();
        {vcc_req, vpp_req, attr_space, dma_ack_req, addr_oe} = 7'($urandom);
        {cbe3_out_n, cbe3_oe, card_clk_en, card_clk_src} = 4'($urandom);
        {card_audio_line, card_status_change} = 2'($urandom);
        {card_detect_pair_n, card_voltage_sense} = 4'($urandom);
        {addr_16, cad_out, cad_oe} = 18'($urandom);
        {cb_ctl_out_n, cb_ctl_oe, card_oe} = 20'($urandom);
        card_val = 10'($urandom);
        card_identified = ($urandom_range(7) == 0);
        socket_mode = 2'($urandom);
        cycle_kind = 3'($urandom_range(3));
        dma_capable = 1'($urandom);
    endtask
    // One cycle of stimulus and its noted outcome
    task automatic drive();
        spm_exp_s e;
        @(posedge clk);
        #1;
        stim();
        e.mv = vcc_req == 2'h1 ? 16'h1388 : vcc_req == 2'h2 ? 16'h0ce4 : '0;
        e.pp = (e.mv == '0 || vpp_req == 2'h3) ? 2'h0 : vpp_req;
        e.st = {card_detect_pair_n, card_voltage_sense, card_audio_line,
                card_status_change};
        if (m == 2'h2) begin
            e.hi = {cad_out[19], cad_out[17], cb_ctl_out_n, 1'b0, cad_out[16],
                    card_clk_en ? card_clk_src : 1'b1};
            e.hoe = {cad_oe[19], cad_oe[17], cb_ctl_oe, 1'b0, cad_oe[16],
                     1'b1};
            e.rs = cbe3_out_n;
            e.ro = cbe3_oe;
            e.dk = 1'b0;
        end else begin
            e.hi = addr_16;
            e.hoe = {10{addr_oe}};
            e.ro = 1'b1;
            e.dk = (cycle_kind == 3'h3) && dma_capable && dma_ack_req;
            if (cycle_kind == 3'h3 && dma_capable) e.rs = !dma_ack_req;
            else if (m == 2'h1) e.rs = 1'b1;
            else if (cycle_kind == 3'h1) e.rs = !attr_space;
            else e.rs = (cycle_kind != 3'h2);
        end
        if (card_identified) m = socket_mode;
        e.cb = (m == 2'h2);
        q.push_back(e);
    endtask
    // Wire level just before each capturing edge
    always @(negedge clk) begin
        neg_ctl = sock_hi_in[23:19];
        neg_cad = {sock_hi_in[25], 1'b1, sock_hi_in[24], sock_hi_in[17]};
        neg_rs = reg_sel_in;
    end
    // Outputs against the oldest note
    always @(posedge clk) begin
        spm_exp_s e;
        #0.5;
        if (q.size() > 0) begin
            e = q.pop_front();
            chk("vcc_mv", vcc_mv, e.mv);
            chk("prog", {prog_volt_sel_a, prog_volt_sel_b}, e.pp);
            chk("reg_sel", reg_sel_out, e.rs);
            chk("hi_oe", sock_hi_oe, e.hoe);
            chk("hi_out", sock_hi_out & e.hoe, e.hi & e.hoe);
            chk("cb_active", cardbus_active, e.cb);
            chk("ctl_in", cb_ctl_in_n, neg_ctl);
            chk("reg_oe", reg_sel_oe, e.ro);
            chk("dma_ack", dma_acknowledge, e.dk);
            chk("status", stat_q, e.st);
            chk("cad_in", cad_in, neg_cad);
            chk("cbe3_in", cbe3_in_n, neg_rs);
        end
    end
    // Hang guard, well above the planned run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(32'hc93bee3e));
        stim();
        card_identified = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (600) drive();
        // Mid-run reset returns power and pins to safe levels
        @(posedge clk);
        #1;
        nrst = 1'b0;
        card_identified = 1'b0;
        m = 2'h0;
        @(posedge clk);
        #1;
        chk("rst_pwr", {supply_sel_low_n, supply_sel_high_n,
            prog_volt_sel_a, prog_volt_sel_b}, 4'hc);
        chk("rst_oe", sock_hi_oe, 10'h000);
        chk("rst_stat", stat_q, 6'h3c);
        nrst = 1'b1;
        repeat (300) drive();
        repeat (2) @(posedge clk);
        report_and_stop();
    end
endmodule
